/* pdmm_defines.svh */
// Purpose: Constants for the program and data memory map block.
// Assumes: Included by bare name; definitions only.
// Notes:   Offsets are 7-bit file addresses unless noted.
`ifndef PDMM_DEFINES_SVH
`define PDMM_DEFINES_SVH

`define PDMM_PC_W          13
`define PDMM_INSN_W        14
`define PDMM_IMPL_AW       11
`define PDMM_RESET_VEC     13'h0000
`define PDMM_INT_VEC       13'h0004
`define PDMM_BSEL_HI_BIT   6
`define PDMM_BSEL_LO_BIT   5
`define PDMM_FILE_W        7
`define PDMM_DADDR_W       9
`define PDMM_GPR_BASE      7'h20
`define PDMM_SHARED_BASE   7'h70
`define PDMM_OFS_INDIRECT  7'h00
`define PDMM_OFS_PCL       7'h02
`define PDMM_OFS_STATUS    7'h03
`define PDMM_OFS_POINTER   7'h04
`define PDMM_OFS_PCLATH    7'h0a
`define PDMM_OFS_INTCON    7'h0b
`define PDMM_STATUS_RST    8'h18
`define PDMM_BANK1_GPR_END 7'h6f

`endif

/* pdmm_pkg.sv */
// Purpose: Types shared by the memory map block.
// Assumes: Nothing beyond the defines header.
// Notes:   Target classes of a decoded data access.
package pdmm_pkg;
   typedef enum logic [2:0] {
      PDMM_TGT_SFR,
      PDMM_TGT_GPR,
      PDMM_TGT_CORE,
      PDMM_TGT_NONE
   } pdmm_tgt_t;
endpackage : pdmm_pkg

/* pdmm_prog_map.sv */
// Purpose: Program counter and program memory addressing.
// Assumes: Core supplies load, interrupt and increment strobes.
// Notes:   Upper program counter bits are dropped when fetching.
`timescale 1ns/10ps
`include "pdmm_defines.svh"
module pdmm_prog_map
   import pdmm_pkg::*;
#(
   parameter int PC_W    = `PDMM_PC_W,
   parameter int IMPL_AW = `PDMM_IMPL_AW
) (
   // Clock, reset and enable.
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // Program counter control.
   input  wire logic              pc_inc,
   input  wire logic              pc_load,
   input  wire logic [PC_W-1:0]   pc_target,
   input  wire logic              int_take,
   // Results.
   output logic      [PC_W-1:0]   pc,
   output logic      [IMPL_AW-1:0] fetch_addr
);
   logic [PC_W-1:0] next_pc;

   // Interrupt entry outranks a jump, which outranks a step.
   always_comb begin
      next_pc = pc;
      if (int_take) begin
         next_pc = `PDMM_INT_VEC;
      end else if (pc_load) begin
         next_pc = pc_target;
      end else if (pc_inc) begin
         next_pc = pc + 1'b1;
      end
   end

   // Counter and registered fetch address stay in step.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pc         <= `PDMM_RESET_VEC;
         fetch_addr <= '0;
      end else if (ce) begin
         pc         <= next_pc;
         fetch_addr <= next_pc[IMPL_AW-1:0];
      end
   end
endmodule : pdmm_prog_map

/* pdmm_mem_map.sv */
// Purpose: Program and data memory map with banked register file.
// Assumes: Core drives strobes synchronous to mclk; read data is
//          registered and valid the cycle after the request.
// Notes:   Peripheral special registers are forwarded on the sfr ports.
`timescale 1ns/10ps
`include "pdmm_defines.svh"
module pdmm_mem_map
   import pdmm_pkg::*;
#(
   parameter int PC_W    = `PDMM_PC_W,
   parameter int INSN_W  = `PDMM_INSN_W,
   parameter int IMPL_AW = `PDMM_IMPL_AW,
   parameter int PDEPTH  = 2048
) (
   // Clock, reset and enable.
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   // Program counter control from the core.
   input  wire logic               pc_inc,
   input  wire logic               pc_load,
   input  wire logic [PC_W-1:0]    pc_target,
   input  wire logic               int_take,
   // Program memory load port.
   input  wire logic               prog_we,
   input  wire logic [IMPL_AW-1:0] prog_waddr,
   input  wire logic [INSN_W-1:0]  prog_wdata,
   // Data access from the core.
   input  wire logic               d_rd,
   input  wire logic               d_wr,
   input  wire logic [6:0]         d_faddr,
   input  wire logic [7:0]         d_wdata,
   // Peripheral special register return data.
   input  wire logic [7:0]         sfr_rdata,
   // Program counter and fetch results.
   output logic      [PC_W-1:0]    pc,
   output logic      [INSN_W-1:0]  insn,
   // Data results.
   output logic      [7:0]         d_rdata,
   output logic      [7:0]         status,
   output logic      [7:0]         indirect_pointer,
   output logic      [1:0]         bank_select_field,
   // Forwarded peripheral special register access.
   output logic                    sfr_rd,
   output logic                    sfr_wr,
   output logic      [8:0]         sfr_addr,
   output logic      [7:0]         sfr_wdata
);
   logic [IMPL_AW-1:0] fetch_addr;
   logic [INSN_W-1:0]  prog_mem [PDEPTH];
   logic [7:0]         gpr_mem  [256];
   logic [7:0]         pclath;
   logic [7:0]         intcon;
   logic [8:0]         eff_addr;
   logic               indirect;
   pdmm_tgt_t          tgt;
   logic [7:0]         gpr_index;
   logic               bank_select_high;
   logic               bank_select_low;

   // Decodes a full data address into its target class.
   function automatic pdmm_tgt_t decode(input logic [8:0] a);
      logic [6:0] f;
      f = a[6:0];
      if (f == `PDMM_OFS_INDIRECT || f == `PDMM_OFS_PCL ||
          f == `PDMM_OFS_STATUS || f == `PDMM_OFS_POINTER ||
          f == `PDMM_OFS_PCLATH || f == `PDMM_OFS_INTCON) begin
         decode = PDMM_TGT_CORE;
      end else if (f < `PDMM_GPR_BASE) begin
         decode = PDMM_TGT_SFR;
      end else if (f >= `PDMM_SHARED_BASE) begin
         decode = PDMM_TGT_GPR;
      end else if (a[8:7] == 2'b00 || a[8:7] == 2'b10) begin
         decode = PDMM_TGT_GPR;
      end else if (f <= `PDMM_BANK1_GPR_END - 7'h10 &&
                   a[8:7] != 2'b00) begin
         decode = PDMM_TGT_GPR;
      end else begin
         decode = PDMM_TGT_NONE;
      end
   endfunction : decode

   // Maps an address onto the static RAM row it aliases.
   function automatic logic [7:0] ram_row(input logic [8:0] a);
      if (a[6:0] >= `PDMM_SHARED_BASE) begin
         ram_row = {1'b0, a[6:0]}; // Shared top rows, one copy.
      end else begin
         ram_row = {a[7], a[6:0]}; // Banks 2/3 alias banks 0/1.
      end
   endfunction : ram_row

   // Program counter sits in its own module on the fetch bus.
   pdmm_prog_map #(
      .PC_W    (PC_W),
      .IMPL_AW (IMPL_AW)
   ) u_prog (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .ce         (ce),
      .pc_inc     (pc_inc),
      .pc_load    (pc_load),
      .pc_target  (pc_target),
      .int_take   (int_take),
      .pc         (pc),
      .fetch_addr (fetch_addr)
   );

   // Bank bits live in status so software sees one copy.
   assign bank_select_high = status[`PDMM_BSEL_HI_BIT];
   assign bank_select_low  = status[`PDMM_BSEL_LO_BIT];

   // Indirect access uses the pointer plus the high bank bit.
   always_comb begin
      indirect = (d_faddr == `PDMM_OFS_INDIRECT);
      if (indirect) begin
         eff_addr = {bank_select_high, indirect_pointer};
      end else begin
         eff_addr = {bank_select_high, bank_select_low,
                     d_faddr};
      end
      tgt       = decode(eff_addr);
      gpr_index = ram_row(eff_addr);
   end

   // Program memory is read on the fetch bus, independent of data.
   always_ff @(posedge mclk) begin
      if (ce && prog_we) begin
         prog_mem[prog_waddr] <= prog_wdata;
      end
   end

   // Fetch is registered one cycle behind the counter.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         insn <= '0;
      end else if (ce) begin
         insn <= prog_mem[fetch_addr];
      end
   end

   // General purpose RAM; the array itself has no reset.
   always_ff @(posedge mclk) begin
      if (ce && d_wr && tgt == PDMM_TGT_GPR) begin
         gpr_mem[gpr_index] <= d_wdata;
      end
   end

   // Core special registers, reached directly or through the pointer;
   // a pointer naming the indirect slot writes nothing, as it has no cell.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status           <= `PDMM_STATUS_RST;
         indirect_pointer <= '0;
         pclath           <= '0;
         intcon           <= '0;
      end else if (ce && d_wr && tgt == PDMM_TGT_CORE) begin
         unique case (eff_addr[6:0])
            `PDMM_OFS_STATUS:  status           <= d_wdata;
            `PDMM_OFS_POINTER: indirect_pointer <= d_wdata;
            `PDMM_OFS_PCLATH:  pclath           <= d_wdata;
            `PDMM_OFS_INTCON:  intcon           <= d_wdata;
            default: ;
         endcase
      end
   end

   // Registered copy of the bank field for the core's use.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bank_select_field <= '0;
      end else if (ce) begin
         bank_select_field <= {status[`PDMM_BSEL_HI_BIT],
                               status[`PDMM_BSEL_LO_BIT]};
      end
   end

   // Forward peripheral accesses; strobes copy the core's request one cycle later.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sfr_rd    <= 1'b0;
         sfr_wr    <= 1'b0;
         sfr_addr  <= '0;
         sfr_wdata <= '0;
      end else if (ce) begin
         sfr_rd    <= d_rd && tgt == PDMM_TGT_SFR;
         sfr_wr    <= d_wr && tgt == PDMM_TGT_SFR;
         sfr_addr  <= eff_addr;
         sfr_wdata <= d_wdata;
      end
   end

   // Read mux; peripheral data is passed through as it returns.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         d_rdata <= '0;
      end else if (ce && d_rd) begin
         unique case (tgt)
            PDMM_TGT_GPR:  d_rdata <= gpr_mem[gpr_index];
            PDMM_TGT_SFR:  d_rdata <= sfr_rdata;
            PDMM_TGT_CORE: begin
               unique case (eff_addr[6:0])
                  `PDMM_OFS_PCL:     d_rdata <= pc[7:0];
                  `PDMM_OFS_STATUS:  d_rdata <= status;
                  `PDMM_OFS_POINTER: d_rdata <= indirect_pointer;
                  `PDMM_OFS_PCLATH:  d_rdata <= pclath;
                  `PDMM_OFS_INTCON:  d_rdata <= intcon;
                  default:           d_rdata <= '0;
               endcase
            end
            default:       d_rdata <= '0;
         endcase
      end
   end
endmodule : pdmm_mem_map

/* pdmm_sfr_model.sv */
// Purpose: Peripheral register stand-in behind the forwarded sfr port.
// Assumes: Read data is taken in the cycle of the core's read strobe.
// Notes:   Outside a read the bus shows the inverse, never a stale value.
`timescale 1ns/10ps
module pdmm_sfr_model (
   // Core data request.
   input  wire logic       d_rd,
   input  wire logic [6:0] d_faddr,
   // Returned peripheral data.
   output logic      [7:0] sfr_rdata
);
   // Each address answers its own tagged value, so misrouting shows.
   assign sfr_rdata = d_rd ? {1'b1, d_faddr} : ~{1'b1, d_faddr};
endmodule : pdmm_sfr_model

/* pdmm_mem_map_checker.sv */
// Purpose: Port checker for the memory map block.
// Assumes: Clock enable and strobes are sampled on the rising edge.
// Notes:   All answers are one cycle after the request.
`timescale 1ns/10ps
module pdmm_mem_map_checker #(parameter int PC_W = 13) (
   // Clock and reset.
   input wire logic            mclk,
   input wire logic            rst_n,
   // Core requests.
   input wire logic            ce,
   input wire logic            pc_inc,
   input wire logic            pc_load,
   input wire logic            int_take,
   input wire logic [PC_W-1:0] pc_target,
   input wire logic            d_rd,
   input wire logic            d_wr,
   input wire logic [6:0]      d_faddr,
   input wire logic [7:0]      d_wdata,
   // Results.
   input wire logic [PC_W-1:0] pc,
   input wire logic [7:0]      d_rdata,
   input wire logic [7:0]      status,
   input wire logic [1:0]      bank_select_field,
   input wire logic            sfr_rd,
   input wire logic            sfr_wr,
   input wire logic [8:0]      sfr_addr,
   input wire logic [7:0]      sfr_wdata
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // A plain read of one file address range in the current bank.
   sequence rd_in(lo, hi);
      ce && d_rd && !d_wr && d_faddr >= lo && d_faddr <= hi;
   endsequence
   // A plain write of one file address range in the current bank.
   sequence wr_in(lo, hi);
      ce && d_wr && !d_rd && d_faddr >= lo && d_faddr <= hi;
   endsequence
   reset_vec_a: assert property (
      $rose(rst_n) |-> pc == 13'h0000)
      else $error("pc not at reset vector");
   int_vec_a: assert property (
      ce && int_take |=> pc == 13'h0004)
      else $error("interrupt vector wrong");
   pc_load_a: assert property (ce && pc_load && !int_take
      |=> pc == $past(pc_target)) else $error("pc load lost");
   pc_step_a: assert property (
      ce && pc_inc && !pc_load && !int_take
      |=> pc == $past(pc) + 13'h0001) else $error("pc step wrong");
   bank_field_a: assert property (ce |=>
      bank_select_field == $past(status[6:5])) else $error("bank field");
   // Core registers at 0Ah and 0Bh sit inside the peripheral range.
   sfr_fwd_a: assert property (
      rd_in(7'h05, 7'h1f) ##0 (d_faddr != 7'h0a && d_faddr != 7'h0b)
      |=> sfr_rd && sfr_addr == {$past(status[6:5]), $past(d_faddr)})
      else $error("sfr forward wrong");
   sfr_write_a: assert property (
      wr_in(7'h05, 7'h09) |=> sfr_wr && sfr_wdata == $past(d_wdata))
      else $error("sfr write not forwarded");
   unimpl_zero_a: assert property (
      rd_in(7'h60, 7'h6f) ##0 status[5]
      |=> d_rdata == 8'h00) else $error("unimplemented not zero");
   status_alias_a: assert property (rd_in(7'h03, 7'h03)
      |=> !sfr_rd && d_rdata == $past(status)) else $error("status read");
   ce_freeze_a: assert property (
      !ce |=> pc == $past(pc) && status == $past(status))
      else $error("state moved while disabled");
endmodule : pdmm_mem_map_checker
bind pdmm_mem_map pdmm_mem_map_checker #(.PC_W(PC_W)) u_chk (.mclk, .rst_n,
   .ce, .pc_inc, .pc_load, .int_take, .pc_target, .d_rd, .d_wr, .d_faddr,
   .d_wdata, .pc, .d_rdata, .status, .bank_select_field, .sfr_rd, .sfr_wr,
   .sfr_addr, .sfr_wdata);

/* test_program_and_data_memory_map.sv */
// Purpose: Directed bench for the program and data memory map.
// Assumes: Inputs change on the falling edge; answers settle by the next.
// Notes:   Clock enable drops for one cycle to show that the counter holds.
`timescale 1ns/10ps
module test_program_and_data_memory_map;
   logic        mclk, rst_n, ce, pc_inc, pc_load, int_take, prog_we;
   logic        d_rd, d_wr;
   logic [12:0] pc_target, pc;
   logic [10:0] prog_waddr;
   logic [13:0] prog_wdata, insn;
   logic [6:0]  d_faddr;
   logic [7:0]  d_wdata, sfr_rdata, d_rdata, status, indirect_pointer;
   int          n_mismatch = 0, compares = 0, cyc = 0;
   pdmm_mem_map dut (.mclk, .rst_n, .ce, .pc_inc, .pc_load, .pc_target,
      .int_take, .prog_we, .prog_waddr, .prog_wdata, .d_rd, .d_wr, .d_faddr,
      .d_wdata, .sfr_rdata, .pc, .insn, .d_rdata, .status,
      .indirect_pointer, .bank_select_field(), .sfr_rd(), .sfr_wr(),
      .sfr_addr(), .sfr_wdata());
   pdmm_sfr_model peer (.d_rd, .d_faddr, .sfr_rdata);
   // Free running clock at 200 MHz.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // A hang is cut short well past the expected run length.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One data access; a read leaves its answer on d_rdata on return.
   task automatic dacc(input logic wr, input logic [6:0] a,
                       input logic [7:0] d);
      @(negedge mclk);
      d_rd = !wr;
      d_wr = wr;
      d_faddr = a;
      d_wdata = d;
      @(negedge mclk);
      d_rd = 1'b0;
      d_wr = 1'b0;
   endtask : dacc
   task automatic t_reset();
      chk({1'b0, pc}, 14'h0000);
      chk({6'h00, status}, 14'h0018);
   endtask : t_reset
   // The interrupt vector, far loads that wrap onto 2K words, and the 13-bit step.
   task automatic t_prog();
      for (int i = 4; i < 6; i++) begin
         @(negedge mclk);
         prog_we = 1'b1;
         prog_waddr = 11'(i);
         prog_wdata = 14'h2aa0 + 14'(i);
      end
      @(negedge mclk);
      prog_we = 1'b0;
      int_take = 1'b1;
      @(negedge mclk);
      int_take = 1'b0;
      chk({1'b0, pc}, 14'h0004);
      @(negedge mclk);
      chk(insn, 14'h2aa4);
      pc_load = 1'b1;
      pc_target = 13'h1805;
      @(negedge mclk);
      pc_target = 13'h1fff;
      chk({1'b0, pc}, 14'h1805);
      @(negedge mclk);
      chk(insn, 14'h2aa5);
      pc_load = 1'b0;
      pc_inc = 1'b1;
      @(negedge mclk);
      pc_inc = 1'b0;
      chk({1'b0, pc}, 14'h0000);
      // A step request with the enable low must leave the counter alone.
      ce = 1'b0;
      pc_inc = 1'b1;
      @(negedge mclk);
      ce = 1'b1;
      pc_inc = 1'b0;
      chk({1'b0, pc}, 14'h0000);
   endtask : t_prog
   // Banked RAM, unimplemented rows, forwarding, sharing and the pointer.
   task automatic t_data();
      dacc(1'b1, 7'h20, 8'h55);
      dacc(1'b1, 7'h03, 8'h38);
      dacc(1'b1, 7'h20, 8'haa);
      dacc(1'b0, 7'h60, 8'h00);
      chk({6'h00, d_rdata}, 14'h0000);
      dacc(1'b0, 7'h20, 8'h00);
      chk({6'h00, d_rdata}, 14'h00aa);
      dacc(1'b0, 7'h05, 8'h00);
      chk({6'h00, d_rdata}, 14'h0085);
      dacc(1'b1, 7'h70, 8'h77);
      dacc(1'b1, 7'h03, 8'h18);
      pc_inc = 1'b1;
      dacc(1'b0, 7'h70, 8'h00);
      pc_inc = 1'b0;
      chk({6'h00, d_rdata}, 14'h0077);
      chk({1'b0, pc}, 14'h0002);
      dacc(1'b0, 7'h20, 8'h00);
      chk({6'h00, d_rdata}, 14'h0055);
      dacc(1'b1, 7'h04, 8'h20);
      chk({6'h00, indirect_pointer}, 14'h0020);
      dacc(1'b0, 7'h00, 8'h00);
      chk({6'h00, d_rdata}, 14'h0055);
      // A core register written through the pointer reads back directly.
      dacc(1'b1, 7'h04, 8'h0a);
      dacc(1'b1, 7'h00, 8'h5a);
      dacc(1'b0, 7'h0a, 8'h00);
      chk({6'h00, d_rdata}, 14'h005a);
      // A peripheral write is forwarded; the run ends before the checker samples the strobe.
      dacc(1'b1, 7'h05, 8'h3c);
   endtask : t_data
   task automatic complete_run();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   // Reset for 20 cycles, then the scenarios in turn.
   initial begin
      {rst_n, ce, pc_inc, pc_load, int_take, prog_we, d_rd, d_wr} = 8'h40;
      {pc_target, prog_waddr, prog_wdata} = '0;
      {d_faddr, d_wdata} = '0;
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      t_reset();
      t_prog();
      t_data();
      complete_run();
   end
endmodule : test_program_and_data_memory_map
